// ==== shared/port_defs.vh ====
// Notes on behaviour
// - Pair pull-up only when input or open-drain
// - Pair readback: pin, or 0 when push-pull output
// - Quad port has four pins, bits 7 to 4
// - Quad push-pull output drives latch value low or high
// - Quad drive type: 0 push-pull, 1 open-drain
// - Function bits route peripheral outputs to pins only when bank select is 1
// - Only bits 6 to 4 have function; bit7 zero
// - Quad readback: pin, or 0 when push-pull output
// - Bank select 1 routes serial onto quad pins
`ifndef PORT_DEFS_VH
`define PORT_DEFS_VH

////////////////////////////////////////////////////////////////////////////
// Register byte addresses
`define ADDR_QUAD_LATCH     12'h00B
`define ADDR_PAIR_READBACK  12'h016
`define ADDR_QUAD_READBACK  12'h018
`define ADDR_QUAD_DIR       12'hF25
`define ADDR_PAIR_PULLUP    12'hF30
`define ADDR_QUAD_FUNC      12'hF3F
`define ADDR_QUAD_DRIVE     12'hF4C
`define ADDR_SERIAL_SELECT  12'hFCB

////////////////////////////////////////////////////////////////////////////
// Implemented bit masks
`define MASK_QUAD           8'hF0
`define MASK_QUAD_FUNC      8'h70
`define MASK_PAIR           8'h03
`define MASK_BANK           8'h10

////////////////////////////////////////////////////////////////////////////
// Field positions
`define QUAD_LSB            4
`define BANK_BIT            4

////////////////////////////////////////////////////////////////////////////
// Reset values
`define RST_CTRL            8'h00
`define RST_BYTE            8'h00

`endif

// ==== rtl/port_pin_cell.v ====
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// One quad port pin: drive selection and registered pin drive
module port_pin_cell
(
    // Clock and reset
    input  wire clk_sys,
    input  wire nrst,
    input  wire ce,
    // Control bits for this pin
    input  wire dir,        // 1 selects output mode
    input  wire open_drain, // 1 selects sink open drain
    input  wire use_alt,    // 1 selects peripheral output
    input  wire latch,      // Port output latch bit
    input  wire alt_val,    // Peripheral output level
    // Pin side
    output reg  pin_out,    // Level driven onto the pin
    output reg  pin_oe      // High while the pin is driven
);

    ////////////////////////////////////////////////////////////////////////
    // Combinational drive decision
    reg next_out;           // Level chosen for the pin
    reg next_oe;            // Drive enable chosen for the pin

    // Source select, then drive style
    always @*
    begin
        // Peripheral or latch feeds the pin
        next_out = use_alt ? alt_val : latch;
        if (!dir)
        begin
            // Input mode never drives
            next_oe = 1'b0;
        end
        else if (open_drain)
        begin
            // Open drain only sinks; high is released
            next_oe = ~next_out;
        end
        else
        begin
            // Push-pull drives both levels
            next_oe = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered pin drive, released at reset
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            // Pins float as inputs after reset
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end
        else if (ce)
        begin
            // One cycle of latency from control to pin
            pin_out <= next_out;
            pin_oe  <= next_oe;
        end
    end

endmodule // port_pin_cell

`default_nettype wire

// ==== rtl/quad_pair_port.v ====
`timescale 1ns/1ps
`default_nettype none
`include "port_defs.vh"

////////////////////////////////////////////////////////////////////////////
// Quad port pin logic plus pull-up and readback for the pin pair
module quad_pair_port
#(
    parameter QUAD_PINS = 4,   // Pins of the quad port
    parameter PAIR_PINS = 2    // Pins of the pin pair port
)
(
    // Clock, reset and clock enable
    input  wire                 clk_sys,
    input  wire                 nrst,
    input  wire                 ce,
    // Register port
    input  wire [11:0]          addr,
    input  wire [7:0]           wdata,
    input  wire                 wr,
    input  wire                 rd,
    output reg  [7:0]           rdata,
    // Quad port pins, bit 0 here is port bit 4
    input  wire [QUAD_PINS-1:0] quad_pin_in,
    output wire [QUAD_PINS-1:0] quad_pin_out,
    output wire [QUAD_PINS-1:0] quad_pin_oe,
    // Peripheral outputs offered to the quad port
    input  wire                 sync_serial_clock,
    input  wire                 sync_serial_out,
    input  wire                 async_transmit,
    input  wire                 sync_serial_mode,
    // Peripheral inputs taken from the quad port
    output reg                  async_receive,
    output reg                  sync_serial_in,
    output reg                  serial_bank_quad,
    // Pin pair port state kept outside this block
    input  wire [PAIR_PINS-1:0] pin_pair_direction,
    input  wire [PAIR_PINS-1:0] pin_pair_drive_type,
    input  wire [PAIR_PINS-1:0] pair_pin_in,
    output reg  [PAIR_PINS-1:0] pair_pullup_on
);

    ////////////////////////////////////////////////////////////////////////
    // Shared readback rule: pin level unless push-pull output
    function readback_bit;
        input dir_bit;
        input drive_bit;
        input pin_bit;
        begin
            // Push-pull output reads zero, all else the pin
            readback_bit = (dir_bit & ~drive_bit) ? 1'b0 : pin_bit;
        end
    endfunction

    // Pull-up may connect only in input or open drain
    function pullup_allowed;
        input enable_bit;
        input dir_bit;
        input drive_bit;
        begin
            pullup_allowed = enable_bit & (~dir_bit | drive_bit);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Software-visible control registers
    reg [QUAD_PINS-1:0] quad_port_output_latch;  // Latch, bits 7..4
    reg [QUAD_PINS-1:0] quad_port_direction;     // 1 = output
    reg [QUAD_PINS-2:0] quad_port_alt_function;  // Bits 6..4 only
    reg [QUAD_PINS-1:0] quad_port_drive_type;    // 1 = open drain
    reg [PAIR_PINS-1:0] pin_pair_pullup_enable;  // Pull-up request
    reg                 serial_pin_bank_select;  // 1 = quad pins

    ////////////////////////////////////////////////////////////////////////
    // Address decode for writes
    wire wr_latch  = wr && (addr == `ADDR_QUAD_LATCH);
    wire wr_dir    = wr && (addr == `ADDR_QUAD_DIR);
    wire wr_func   = wr && (addr == `ADDR_QUAD_FUNC);
    wire wr_drive  = wr && (addr == `ADDR_QUAD_DRIVE);
    wire wr_pullup = wr && (addr == `ADDR_PAIR_PULLUP);
    wire wr_bank   = wr && (addr == `ADDR_SERIAL_SELECT);

    // Register writes; only implemented bits are stored
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            // Every pin an input, push-pull, port function
            quad_port_output_latch <= {QUAD_PINS{1'b0}};
            quad_port_direction    <= {QUAD_PINS{1'b0}};
            quad_port_alt_function <= {(QUAD_PINS-1){1'b0}};
            quad_port_drive_type   <= {QUAD_PINS{1'b0}};
            pin_pair_pullup_enable <= {PAIR_PINS{1'b0}};
            serial_pin_bank_select <= 1'b0;
        end
        else if (ce)
        begin
            // Latch for bits 7..4
            if (wr_latch)
            begin
                quad_port_output_latch <=
                    wdata[`QUAD_LSB +: QUAD_PINS];
            end
            // Direction per pin
            if (wr_dir)
            begin
                quad_port_direction <=
                    wdata[`QUAD_LSB +: QUAD_PINS];
            end
            // Function, bit 7 not stored
            if (wr_func)
            begin
                quad_port_alt_function <=
                    wdata[`QUAD_LSB +: (QUAD_PINS-1)];
            end
            // Drive type per pin
            if (wr_drive)
            begin
                quad_port_drive_type <=
                    wdata[`QUAD_LSB +: QUAD_PINS];
            end
            // Pair pull-up request bits 1..0
            if (wr_pullup)
            begin
                pin_pair_pullup_enable <= wdata[PAIR_PINS-1:0];
            end
            // Only the bank bit exists here
            if (wr_bank)
            begin
                serial_pin_bank_select <= wdata[`BANK_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Peripheral output per quad pin (index 0 is port bit 4)
    // Bit 4 carries serial out or async transmit by peripheral mode
    wire [QUAD_PINS-1:0] alt_level;  // Peripheral level per pin
    assign alt_level = {1'b0,
                        sync_serial_clock,
                        async_transmit,
                        (sync_serial_mode ? sync_serial_out
                                          : async_transmit)};

    // Function bit counts only when serial routing is on quad pins;
    // otherwise the pin would carry a signal the peripheral is not using
    wire [QUAD_PINS-1:0] alt_select; // Peripheral chosen per pin
    assign alt_select = {1'b0,
                         quad_port_alt_function &
                         {(QUAD_PINS-1){serial_pin_bank_select}}};

    ////////////////////////////////////////////////////////////////////////
    // One drive cell per quad pin
    genvar gi;
    generate
        for (gi = 0; gi < QUAD_PINS; gi = gi + 1)
        begin : g_quad
            port_pin_cell u_cell
            (
                .clk_sys    (clk_sys),
                .nrst       (nrst),
                .ce         (ce),
                .dir        (quad_port_direction[gi]),
                .open_drain (quad_port_drive_type[gi]),
                .use_alt    (alt_select[gi]),
                .latch      (quad_port_output_latch[gi]),
                .alt_val    (alt_level[gi]),
                .pin_out    (quad_pin_out[gi]),
                .pin_oe     (quad_pin_oe[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Readback values, computed from live pin levels
    reg [QUAD_PINS-1:0] quad_rb;  // Quad readback bits
    reg [PAIR_PINS-1:0] pair_rb;  // Pair readback bits
    integer k;

    // Apply the readback rule bit by bit
    always @*
    begin
        quad_rb = {QUAD_PINS{1'b0}};
        pair_rb = {PAIR_PINS{1'b0}};
        for (k = 0; k < QUAD_PINS; k = k + 1)
        begin
            quad_rb[k] = readback_bit(quad_port_direction[k],
                                      quad_port_drive_type[k],
                                      quad_pin_in[k]);
        end
        for (k = 0; k < PAIR_PINS; k = k + 1)
        begin
            pair_rb[k] = readback_bit(pin_pair_direction[k],
                                      pin_pair_drive_type[k],
                                      pair_pin_in[k]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read multiplexer; unmapped addresses and empty bits give zero
    reg [7:0] next_rdata;  // Byte presented next cycle

    always @*
    begin
        next_rdata = `RST_BYTE;
        case (addr)
            `ADDR_QUAD_LATCH:
            begin
                next_rdata[`QUAD_LSB +: QUAD_PINS] =
                    quad_port_output_latch;
            end
            `ADDR_QUAD_DIR:
            begin
                next_rdata[`QUAD_LSB +: QUAD_PINS] = quad_port_direction;
            end
            `ADDR_QUAD_FUNC:
            begin
                // Bit 7 stays zero
                next_rdata[`QUAD_LSB +: (QUAD_PINS-1)] =
                    quad_port_alt_function;
            end
            `ADDR_QUAD_DRIVE:
            begin
                next_rdata[`QUAD_LSB +: QUAD_PINS] = quad_port_drive_type;
            end
            `ADDR_PAIR_PULLUP:
            begin
                next_rdata[PAIR_PINS-1:0] = pin_pair_pullup_enable;
            end
            `ADDR_SERIAL_SELECT:
            begin
                next_rdata[`BANK_BIT] = serial_pin_bank_select;
            end
            `ADDR_QUAD_READBACK:
            begin
                next_rdata[`QUAD_LSB +: QUAD_PINS] = quad_rb;
            end
            `ADDR_PAIR_READBACK:
            begin
                next_rdata[PAIR_PINS-1:0] = pair_rb;
            end
            default:
            begin
                // Unmapped reads as zero
                next_rdata = `RST_BYTE;
            end
        endcase
    end

    // Read data stand one cycle after the strobe, zero otherwise
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata <= `RST_BYTE;
        end
        else if (ce)
        begin
            // Held at zero between reads so stale data never linger
            rdata <= rd ? next_rdata : `RST_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pull-up and peripheral input routing, registered
    reg [PAIR_PINS-1:0] next_pullup;  // Pull-up permitted per pin
    integer             j;            // Own index, one driver per process

    always @*
    begin
        next_pullup = {PAIR_PINS{1'b0}};
        for (j = 0; j < PAIR_PINS; j = j + 1)
        begin
            next_pullup[j] = pullup_allowed(pin_pair_pullup_enable[j],
                                            pin_pair_direction[j],
                                            pin_pair_drive_type[j]);
        end
    end

    // Peripheral inputs follow bit 5 only when routed to the quad port
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            pair_pullup_on   <= {PAIR_PINS{1'b0}};
            async_receive    <= 1'b0;
            sync_serial_in   <= 1'b0;
            serial_bank_quad <= 1'b0;
        end
        else if (ce)
        begin
            // Pull-up disconnected whenever pin is a push-pull output
            pair_pullup_on   <= next_pullup;
            // Receive and serial-in share pin bit 5
            async_receive    <= serial_pin_bank_select &
                                quad_pin_in[1];
            sync_serial_in   <= serial_pin_bank_select &
                                quad_pin_in[1];
            // Tells the peripherals which pin bank is live
            serial_bank_quad <= serial_pin_bank_select;
        end
    end

endmodule // quad_pair_port

`default_nettype wire

// ==== tb/pin_side_model.sv ====
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Board circuitry on the quad pins and the pair pins
module pin_side_model
(
    // Clock
    input  wire logic       clk_sys,
    // Device drive
    input  wire logic [3:0] quad_pin_out,
    input  wire logic [3:0] quad_pin_oe,
    input  wire logic [1:0] pair_pullup_on,
    // Board side level on undriven quad pins
    input  wire logic [3:0] ext_quad,
    // Resolved pin levels
    output logic      [3:0] quad_pin_in,
    output logic      [1:0] pair_pin_in
);
    logic float_bit = 1'b0; // Stands in for an undriven pin

    // Toggles so a floating pin never reads as a steady level
    always @(posedge clk_sys)
        float_bit <= ~float_bit;

    // Released open-drain pin shows the board level
    assign quad_pin_in = (quad_pin_oe & quad_pin_out) | (~quad_pin_oe & ext_quad);
    // Pull-up holds the pair pin high, else it floats
    assign pair_pin_in = pair_pullup_on | {2{float_bit}};
endmodule // pin_side_model

`default_nettype wire

// ==== tb/quad_pair_port_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "port_defs.vh"

////////////////////////////////////////////////////////////////////////////
// Port checks on the quad and pair pin block
module quad_pair_port_monitor
(
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire logic       ce,
    // Register port
    input wire logic [11:0] addr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    // Pins and peripherals
    input wire logic [3:0] quad_pin_in,
    input wire logic [3:0] quad_pin_oe,
    input wire logic       async_receive,
    input wire logic       sync_serial_in,
    input wire logic       serial_bank_quad,
    input wire logic [1:0] pin_pair_direction,
    input wire logic [1:0] pin_pair_drive_type,
    input wire logic [1:0] pair_pin_in,
    input wire logic [1:0] pair_pullup_on
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    property p_pullup_gate;
        $past(ce) |-> (pair_pullup_on
            & $past(pin_pair_direction & ~pin_pair_drive_type)) == 2'h0;
    endproperty
    a_pullup_gate: assert property (p_pullup_gate)
        else $error("pull-up on for push-pull output");
    property p_pair_read;
        $past(ce && rd && addr == `ADDR_PAIR_READBACK) |-> rdata ==
            {6'h00, $past(pair_pin_in
            & ~(pin_pair_direction & ~pin_pair_drive_type))};
    endproperty
    a_pair_read: assert property (p_pair_read)
        else $error("pair readback wrong");
    property p_quad_read_low;
        $past(ce && rd && addr == `ADDR_QUAD_READBACK) |-> rdata[3:0] == 4'h0;
    endproperty
    a_quad_read_low: assert property (p_quad_read_low)
        else $error("quad readback low nibble set");
    property p_func_bit7;
        $past(ce && rd && addr == `ADDR_QUAD_FUNC) |-> (rdata & 8'h8F) == 8'h00;
    endproperty
    a_func_bit7: assert property (p_func_bit7)
        else $error("function read has bit 7 or low bits");
    property p_idle_rdata;
        $past(ce) && !$past(rd) |-> rdata == 8'h00;
    endproperty
    a_idle_rdata: assert property (p_idle_rdata)
        else $error("read data without read");
    property p_rx_gate;
        $past(ce) && async_receive |-> $past(quad_pin_in[1]);
    endproperty
    a_rx_gate: assert property (p_rx_gate)
        else $error("receive not from bit 5");
    property p_rx_same;
        sync_serial_in == async_receive;
    endproperty
    a_rx_same: assert property (p_rx_same)
        else $error("serial inputs differ");
    property p_reset_state;
        $rose(nrst) |-> quad_pin_oe == 4'h0 && rdata == 8'h00
            && pair_pullup_on == 2'h0 && !serial_bank_quad;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("outputs not idle after reset");
endmodule // quad_pair_port_monitor

bind quad_pair_port quad_pair_port_monitor mon (.clk_sys(clk_sys),
    .nrst(nrst), .ce(ce), .addr(addr), .rd(rd), .rdata(rdata),
    .quad_pin_in(quad_pin_in), .quad_pin_oe(quad_pin_oe),
    .async_receive(async_receive), .sync_serial_in(sync_serial_in),
    .serial_bank_quad(serial_bank_quad),
    .pin_pair_direction(pin_pair_direction),
    .pin_pair_drive_type(pin_pair_drive_type),
    .pair_pin_in(pair_pin_in), .pair_pullup_on(pair_pullup_on));

`default_nettype wire

// ==== tb/quad_pair_port_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "port_defs.vh"

////////////////////////////////////////////////////////////////////////////
// Register-level bench for the quad and pair pin block
module quad_pair_port_test;
    logic        clk_sys = 1'b0;  // 25 MHz
    logic        nrst = 1'b0;     // Held low at start
    logic        ce = 1'b1;       // Clock enable
    logic [11:0] addr = 12'h000;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  rdata;
    logic [3:0]  quad_pin_in, quad_pin_out, quad_pin_oe;
    logic        sclk = 1'b1, ser_out = 1'b0, atx = 1'b1, mode = 1'b1;
    logic        async_receive, sync_serial_in, serial_bank_quad;
    logic [1:0]  pdir = 2'h0, pdrv = 2'h0, pair_pin_in, pair_pullup_on;
    logic [3:0]  ext_quad = 4'hF;  // Board level on free quad pins
    logic [11:0] ra [0:5];         // Writable registers
    logic [7:0]  rm [0:5];         // Their implemented bits
    logic [7:0]  pc [0:3];         // Pair cases: dir,drive,pull-up,read
    integer      bad_count = 0;
    integer      compares = 0;
    integer      i;

    always #20 clk_sys = ~clk_sys;

    quad_pair_port DUT (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .quad_pin_in(quad_pin_in), .quad_pin_out(quad_pin_out),
        .quad_pin_oe(quad_pin_oe), .sync_serial_clock(sclk),
        .sync_serial_out(ser_out), .async_transmit(atx),
        .sync_serial_mode(mode), .async_receive(async_receive),
        .sync_serial_in(sync_serial_in),
        .serial_bank_quad(serial_bank_quad),
        .pin_pair_direction(pdir), .pin_pair_drive_type(pdrv),
        .pair_pin_in(pair_pin_in), .pair_pullup_on(pair_pullup_on));

    pin_side_model pins (.clk_sys(clk_sys), .quad_pin_out(quad_pin_out),
        .quad_pin_oe(quad_pin_oe), .pair_pullup_on(pair_pullup_on),
        .ext_quad(ext_quad), .quad_pin_in(quad_pin_in),
        .pair_pin_in(pair_pin_in));

    ////////////////////////////////////////////////////////////////////////
    // Compare, bus and closing tasks
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        compares = compares + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask

    // One-cycle write strobe
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd_check(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 chk("rdata", exp, rdata);
    endtask

    task automatic end_of_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Cuts a hang short
    initial
    begin
        tick(20000);
        bad_count = bad_count + 1;
        end_of_test;
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        ra = '{`ADDR_QUAD_LATCH, `ADDR_QUAD_DIR, `ADDR_PAIR_PULLUP,
               `ADDR_QUAD_FUNC, `ADDR_QUAD_DRIVE, `ADDR_SERIAL_SELECT};
        rm = '{8'hF0, 8'hF0, 8'h03, 8'h70, 8'hF0, 8'h10};
        pc = '{8'h4A, 8'h5F, 8'hC0, 8'h0F};
        tick(20);
        nrst <= 1'b1;
        for (i = 0; i < 6; i = i + 1)
            rd_check(ra[i], 8'h00);
        for (i = 0; i < 6; i = i + 1)
        begin
            wr_reg(ra[i], 8'hFF);
            rd_check(ra[i], rm[i]);
            wr_reg(ra[i], 8'h00);
        end
        wr_reg(12'h123, 8'hFF);
        rd_check(12'h123, 8'h00);
        $display("register access test done");
        // Push-pull, then open drain on bits 7 and 5
        wr_reg(`ADDR_QUAD_LATCH, 8'h80);
        wr_reg(`ADDR_QUAD_DIR, 8'hA0);
        tick(2);
        chk("oe", 8'h0A, {4'h0, quad_pin_oe});
        chk("out", 8'h08, {4'h0, quad_pin_out & quad_pin_oe});
        rd_check(`ADDR_QUAD_READBACK, 8'h50);
        wr_reg(`ADDR_QUAD_DRIVE, 8'hF0);
        tick(2);
        chk("oe", 8'h02, {4'h0, quad_pin_oe});
        rd_check(`ADDR_QUAD_READBACK, 8'hD0);
        $display("quad drive test done");
        // Peripheral routing only once the bank is selected
        wr_reg(`ADDR_QUAD_DRIVE, 8'h00);
        wr_reg(`ADDR_QUAD_LATCH, 8'h00);
        wr_reg(`ADDR_QUAD_DIR, 8'hF0);
        wr_reg(`ADDR_QUAD_FUNC, 8'hF0);
        tick(2);
        chk("out", 8'h00, {4'h0, quad_pin_out});
        wr_reg(`ADDR_SERIAL_SELECT, 8'h10);
        tick(2);
        chk("out", 8'h06, {4'h0, quad_pin_out});
        mode <= 1'b0;
        tick(2);
        chk("out", 8'h07, {4'h0, quad_pin_out});
        chk("rx", 8'h07, {5'h00, serial_bank_quad, async_receive,
            sync_serial_in});
        sclk <= 1'b0;
        tick(2);
        chk("out", 8'h03, {4'h0, quad_pin_out});
        // Clock enable low: write ignored, pins frozen
        ce <= 1'b0;
        wr_reg(`ADDR_QUAD_LATCH, 8'hF0);
        chk("out", 8'h03, {4'h0, quad_pin_out});
        ce <= 1'b1;
        rd_check(`ADDR_QUAD_LATCH, 8'h00);
        // Bit 5 as input: receive follows the pin level
        wr_reg(`ADDR_QUAD_DIR, 8'hD0);
        ext_quad <= 4'h0;
        tick(3);
        chk("rx", 8'h04, {5'h00, serial_bank_quad, async_receive,
            sync_serial_in});
        $display("alternate function test done");
        // Pull-up and readback of the pin pair
        wr_reg(`ADDR_PAIR_PULLUP, 8'h03);
        for (i = 0; i < 4; i = i + 1)
        begin
            tick(1);
            pdir <= pc[i][7:6];
            pdrv <= pc[i][5:4];
            tick(2);
            chk("pullup", {6'h00, pc[i][3:2]}, {6'h00, pair_pullup_on});
            rd_check(`ADDR_PAIR_READBACK, {6'h00, pc[i][1:0]});
        end
        $display("pin pair test done");
        // Reset in mid-run returns every control to idle
        tick(1);
        nrst <= 1'b0;
        tick(2);
        nrst <= 1'b1;
        tick(1);
        chk("oe", 8'h00, {4'h0, quad_pin_oe});
        chk("rx", 8'h00, {5'h00, serial_bank_quad, async_receive,
            sync_serial_in});
        for (i = 0; i < 6; i = i + 1)
            rd_check(ra[i], 8'h00);
        $display("mid-run reset test done");
        end_of_test;
    end
endmodule // quad_pair_port_test

`default_nettype wire
